// [esp_status_core.sv]
// Encoder status flags, additional data word and parameter memory access.
// Assumes link signals come from another domain; sensor inputs share clk.
//
// Behaviour
// - One warning flag for any tolerance limit
// - Warning cause is kept for later readout
// - Reference flag shows run done; absolute always high
// - Incremental absolute position only after reference
// - Busy low when idle, high during access
// - Selected content persists, refreshed every transfer
// - Each word carries a 5-bit content number
// - Incremental second position: relative count from zero until reference
// - Absolute second position: independent safety position
// - Memory parameters sent with their word address
// - Content acknowledging the latest range selection
// - Sixteen sensors, rolling 4-bit address sent along
// - Access may take up to 12 ms
// - Manufacturer area rejects controller writes
// - Protection set and read via status area
// - Write protection is never cleared
// - Encoder type readable at manufacturer word 14
// - Second error flag sent inverted
// - 30-bit word, low first bit, checksum after
`default_nettype none

module esp_status_core
    import esp_pkg::*;
#(
    parameter int unsigned ACCESS_CYCLES = esp_pkg::ACCESS_CYCLES,
    parameter logic [15:0] ENC_TYPE      = esp_pkg::ENC_TYPE_DEF  // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        link_clk,
    input  wire logic        link_din,
    output var  logic        link_dout,
    output var  logic        link_doe,
    input  wire logic [1:0]  warn_src,
    input  wire logic        fault_a,
    input  wire logic        fault_b,
    input  wire logic        ref_mark,
    input  wire logic        inc_step,
    input  wire logic        inc_dir,
    input  wire logic [15:0] pos_abs,
    input  wire logic [15:0] pos_safe,
    input  wire logic [15:0] sensor_value,
    output var  logic [3:0]  sensor_addr,
    output var  logic        tolerance_warning_flag,
    output var  logic        reference_done_flag,
    output var  logic        busy
);
    import esp_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [2:0]  clk_sync;
    logic [1:0]  din_sync;
    logic        fall_edge;
    logic        rise_edge;
    esp_link_t   link_state;
    logic [8:0]  idle_cnt;
    logic [5:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic [FRAME_BITS-1:0] tx_shift;
    logic [CMD_BITS-2:0]   rx_shift;
    logic        cmd_valid;
    logic [CMD_BITS-1:0]   cmd;
    esp_op_t     cmd_op;
    logic [4:0]  cmd_field;
    logic        ctrl_abs;
    logic [1:0]  cause;
    logic        cause_clr_hit;
    logic [1:0]  wp;
    esp_area_t   area;
    esp_kind_t   kind;
    logic [4:0]  ack_code;
    logic [21:0] busy_cnt;
    logic        accept;
    logic        wr_allowed;
    logic        link_mem_req;
    logic        rd_pending;
    logic [4:0]  rd_word;
    esp_area_t   rd_area;
    logic [15:0] param_val;
    logic [4:0]  param_addr;
    logic        ref_seen;
    logic [15:0] rel_count;
    logic        err1;
    logic        err2;
    logic [WORD_BITS-1:0] word;
    logic [4:0]  w_cid;
    logic [4:0]  w_tag;
    logic [15:0] w_val;
    logic        av_req;
    logic        av_ack;
    logic        av_grant;
    logic [6:0]  av_mem_addr;
    logic        mem_we;
    logic [6:0]  mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;

    // Serial checksum over the word without its leading low bit
    function automatic logic [CRC_BITS-1:0] esp_crc5(input logic [WORD_BITS-2:0] d);
        logic [CRC_BITS-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = WORD_BITS - 2; i >= 0; i--) begin
            fb = c[4] ^ d[i];
            c  = {c[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
        end
        return c;
    endfunction

    // ************************************************************
    // Link pin synchronisers and edge detection
    // ************************************************************
    // Only the later stages feed logic, the first stage may be metastable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clk_sync <= 3'h7;
            din_sync <= 2'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], link_clk};
            din_sync <= {din_sync[0], link_din};
        end
    end
    assign fall_edge = clk_sync[2] & ~clk_sync[1];
    assign rise_edge = ~clk_sync[2] & clk_sync[1];

    // ************************************************************
    // Frame tracking
    // ************************************************************
    // A frame ends once the link clock has rested high long enough
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link_state <= LS_IDLE;
            idle_cnt   <= 9'h000;
        end else begin
            idle_cnt <= clk_sync[1] ? ((idle_cnt == 9'(IDLE_CYCLES)) ? idle_cnt : idle_cnt + 9'h001) : 9'h000;
            case (link_state)
                LS_IDLE: begin
                    if (fall_edge) begin
                        link_state <= LS_FRAME;
                    end
                end
                LS_FRAME: begin
                    if (idle_cnt == 9'(IDLE_CYCLES)) begin
                        link_state <= LS_IDLE;
                    end
                end
                default: link_state <= LS_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Transmit path
    // ************************************************************
    // Word is rebuilt from live values at every frame start
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_shift <= '0;
            tx_cnt   <= 6'h00;
        end else if (fall_edge) begin
            if (link_state == LS_IDLE) begin
                tx_shift <= {err1, ~err2, word, esp_crc5(word[WORD_BITS-2:0])};
                tx_cnt   <= 6'h01;
            end else if (tx_cnt != 6'(FRAME_BITS)) begin
                tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
                tx_cnt   <= tx_cnt + 6'h01;
            end
        end
    end
    assign link_dout = (link_state == LS_FRAME) & tx_shift[FRAME_BITS-1];
    assign link_doe  = (link_state == LS_FRAME);

    // Independent error sources, each registered on its own
    always_ff @(posedge clk) begin
        if (!nrst) begin
            err1 <= 1'b0;
            err2 <= 1'b0;
        end else begin
            err1 <= fault_a;
            err2 <= fault_b;
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    // The first command bits of a frame form one command word
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_shift  <= '0;
            rx_cnt    <= 5'h00;
            cmd_valid <= 1'b0;
            cmd       <= '0;
        end else begin
            cmd_valid <= 1'b0;
            if (link_state == LS_IDLE) begin
                rx_cnt <= 5'h00;
            end else if (rise_edge && rx_cnt != 5'(CMD_BITS)) begin
                rx_shift <= {rx_shift[CMD_BITS-3:0], din_sync[1]};
                rx_cnt   <= rx_cnt + 5'h01;
                if (rx_cnt == 5'(CMD_BITS - 1)) begin
                    cmd       <= {rx_shift, din_sync[1]};
                    cmd_valid <= 1'b1;
                end
            end
        end
    end
    assign cmd_op    = esp_op_t'(cmd[23:22]);
    assign cmd_field = cmd[20:16];

    // ************************************************************
    // Command acceptance and busy timer
    // ************************************************************
    // Requests during busy are dropped; the controller should not send them
    assign accept     = cmd_valid & ~busy & (cmd_op == OP_READ || cmd_op == OP_WRITE);
    assign wr_allowed = (area == AREA_OEM && !wp[0]) || (area == AREA_OPER && !wp[1]);
    assign link_mem_req = accept;
    assign busy = (busy_cnt != 22'h00_0000);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_cnt <= 22'h00_0000;
        end else if (accept) begin
            busy_cnt <= 22'(ACCESS_CYCLES);
        end else if (busy) begin
            busy_cnt <= busy_cnt - 22'h00_0001;
        end
    end

    // Range selection fixes the area and the content kind
    always_ff @(posedge clk) begin
        if (!nrst) begin
            area     <= AREA_MFR;
            kind     <= CK_DIAG;
            ack_code <= 5'h00;
        end else if (cmd_valid && !busy && cmd_op == OP_SELECT) begin
            area     <= esp_area_t'(cmd_field[1:0]);
            kind     <= esp_kind_t'(cmd_field[4:2]);
            ack_code <= cmd_field;
        end
    end

    // Protection bits only ever set; nrst stands for power-on
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp <= 2'b00;
        end else if (accept && cmd_op == OP_WRITE && area == AREA_STATUS && cmd_field == STS_WP_WORD) begin
            wp <= wp | cmd[1:0];
        end
    end

    // Parameter read result, with fixed words overriding the array
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_pending <= 1'b0;
            rd_word    <= 5'h00;
            rd_area    <= AREA_MFR;
            param_val  <= 16'h0000;
            param_addr <= 5'h00;
        end else begin
            rd_pending <= accept & (cmd_op == OP_READ);
            if (accept) begin
                rd_word <= cmd_field;
                rd_area <= area;
            end
            if (rd_pending) begin
                param_addr <= rd_word;
                if (rd_area == AREA_MFR && rd_word == MFR_TYPE_WORD) begin
                    param_val <= ENC_TYPE;
                end else if (rd_area == AREA_STATUS && rd_word == STS_CAUSE_WORD) begin
                    param_val <= {14'h0000, cause};
                end else if (rd_area == AREA_STATUS && rd_word == STS_WP_WORD) begin
                    param_val <= {14'h0000, wp};
                end else begin
                    param_val <= mem_rdata;
                end
            end
        end
    end

    // ************************************************************
    // Status flags and positions
    // ************************************************************
    // Warning is the OR of all limit monitors; cause is sticky, set wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tolerance_warning_flag <= 1'b0;
            cause                  <= 2'b00;
        end else begin
            tolerance_warning_flag <= |warn_src;
            cause <= (cause & ~(cause_clr_hit ? avs_writedata[1:0] : 2'b00)) | warn_src;
        end
    end

    // Reference latch; counter starts from zero after power-up
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_seen  <= 1'b0;
            rel_count <= 16'h0000;
        end else begin
            ref_seen <= ref_seen | ref_mark;
            if (inc_step) begin
                rel_count <= inc_dir ? rel_count - 16'h0001 : rel_count + 16'h0001;
            end
        end
    end
    assign reference_done_flag = ctrl_abs | ref_seen;

    // Rolling sensor address, one step per transmitted frame while sensor content is selected
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sensor_addr <= 4'h0;
        end else if (fall_edge && link_state == LS_IDLE && kind == CK_SENSOR) begin
            sensor_addr <= sensor_addr + 4'h1;
        end
    end

    // ************************************************************
    // Additional data word assembly
    // ************************************************************
    always_comb begin
        w_cid = CID_DIAG;
        w_tag = 5'h00;
        w_val = {12'h000, err1, err2, cause};
        case (kind)
            CK_POS2: begin
                w_cid = CID_POS2;
                if (ctrl_abs) begin
                    w_val = pos_safe;
                end else begin
                    w_val = reference_done_flag ? pos_abs : rel_count;
                end
            end
            CK_MEMPAR: begin
                w_cid = CID_MEMPAR;
                w_tag = param_addr;
                w_val = param_val;
            end
            CK_ACK: begin
                w_cid = CID_ACK;
                w_tag = ack_code;
                w_val = 16'h0000;
            end
            CK_SENSOR: begin
                w_cid = CID_SENSOR;
                w_tag = {1'b0, sensor_addr};
                w_val = sensor_value;
            end
            default: begin
                w_cid = CID_DIAG;
            end
        endcase
        word = {1'b0, tolerance_warning_flag, reference_done_flag, busy, w_cid, w_tag, w_val};
    end

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // Every access waits one cycle, two if a link access takes the memory first; the link keeps memory priority
    assign av_req   = avs_read | avs_write;
    assign av_grant = av_req & ~av_ack & ~link_mem_req;
    assign avs_waitrequest = av_req & ~av_ack;
    assign cause_clr_hit = av_grant & avs_write & (avs_address == REG_CAUSE);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            av_ack <= 1'b0;
        end else begin
            av_ack <= av_grant;
        end
    end

    // Software written control and memory pointer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_abs    <= CTRL_ABS_RST;
            av_mem_addr <= 7'h00;
        end else if (av_grant && avs_write) begin
            if (avs_address == REG_CTRL) begin
                ctrl_abs <= avs_writedata[CTRL_ABS_BIT];
            end
            if (avs_address == REG_MEM_ADDR) begin
                av_mem_addr <= avs_writedata[6:0];
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        avs_readdata = 32'h0000_0000;
        case (avs_address)
            REG_CTRL: avs_readdata[CTRL_ABS_BIT] = ctrl_abs;
            REG_STATUS: begin
                avs_readdata[ST_WARN_BIT] = tolerance_warning_flag;
                avs_readdata[ST_REF_BIT]  = reference_done_flag;
                avs_readdata[ST_BUSY_BIT] = busy;
                avs_readdata[ST_WP_LSB +: 2]   = wp;
                avs_readdata[ST_AREA_LSB +: 2] = area;
                avs_readdata[ST_KIND_LSB +: 3] = kind;
            end
            REG_CAUSE:    avs_readdata[1:0]  = cause;
            REG_MEM_ADDR: avs_readdata[6:0]  = av_mem_addr;
            REG_MEM_DATA: avs_readdata[15:0] = mem_rdata;
            default:      avs_readdata = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Parameter memory
    // ************************************************************
    // Software may preload any area, the controller only the OEM and operator areas while unprotected
    assign mem_we    = link_mem_req ? (cmd_op == OP_WRITE && wr_allowed)
                                    : (av_grant & avs_write & (avs_address == REG_MEM_DATA));
    assign mem_addr  = link_mem_req ? {area, cmd_field} : av_mem_addr;
    assign mem_wdata = link_mem_req ? cmd[15:0] : avs_writedata[15:0];

    esp_param_mem u_mem (
        .clk   (clk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

endmodule // esp_status_core

`default_nettype wire

// [esp_pkg.sv]
// Shared constants and types of the encoder status and parameter memory block.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package esp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 4;
    localparam int ACCESS_TIME_NS = 12_000_000;
    localparam int ACCESS_CYCLES  = ACCESS_TIME_NS / CLK_PERIOD_NS;
    localparam int IDLE_TIME_NS   = 1250;
    localparam int IDLE_CYCLES    = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Link framing sizes
    // ************************************************************
    localparam int CMD_BITS   = 24;
    localparam int WORD_BITS  = 30;
    localparam int CRC_BITS   = 5;
    localparam int FRAME_BITS = 2 + WORD_BITS + CRC_BITS;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_STATUS   = 5'h04;
    localparam logic [4:0] REG_CAUSE    = 5'h08;
    localparam logic [4:0] REG_MEM_ADDR = 5'h0C;
    localparam logic [4:0] REG_MEM_DATA = 5'h10;
    localparam int CTRL_ABS_BIT  = 0;
    localparam int ST_WARN_BIT   = 0;
    localparam int ST_REF_BIT    = 1;
    localparam int ST_BUSY_BIT   = 2;
    localparam int ST_WP_LSB     = 3;
    localparam int ST_AREA_LSB   = 5;
    localparam int ST_KIND_LSB   = 7;
    localparam logic CTRL_ABS_RST = 1'b0;

    // ************************************************************
    // Additional data word layout
    // ************************************************************
    localparam int W_WARN_BIT = 28;
    localparam int W_REF_BIT  = 27;
    localparam int W_BUSY_BIT = 26;
    localparam int W_CID_LSB  = 21;
    localparam int W_TAG_LSB  = 16;
    localparam logic [4:0] CID_DIAG   = 5'h01;
    localparam logic [4:0] CID_POS2   = 5'h02;
    localparam logic [4:0] CID_MEMPAR = 5'h03;
    localparam logic [4:0] CID_ACK    = 5'h04;
    localparam logic [4:0] CID_SENSOR = 5'h05;
    localparam logic [4:0] CRC_POLY   = 5'h05;
    localparam logic [4:0] CRC_INIT   = 5'h1F;

    // ************************************************************
    // Parameter memory words with fixed meaning
    // ************************************************************
    localparam logic [4:0] MFR_TYPE_WORD  = 5'h0E;
    localparam logic [4:0] STS_CAUSE_WORD = 5'h00;
    localparam logic [4:0] STS_WP_WORD    = 5'h01;
    localparam logic [15:0] ENC_TYPE_DEF  = 16'h0001;

    typedef enum logic [1:0] {OP_NONE, OP_SELECT, OP_READ, OP_WRITE} esp_op_t;
    typedef enum logic [1:0] {AREA_MFR, AREA_OEM, AREA_OPER, AREA_STATUS} esp_area_t;
    typedef enum logic [2:0] {CK_DIAG, CK_POS2, CK_MEMPAR, CK_ACK, CK_SENSOR} esp_kind_t;
    typedef enum logic {LS_IDLE, LS_FRAME} esp_link_t;

endpackage

`default_nettype wire

// [esp_param_mem.sv]
// Parameter memory of all four areas, one write/read port.
// Assumes the caller arbitrates between link and bus; read data one cycle late.
`default_nettype none

module esp_param_mem (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [6:0]  addr,
    input  wire logic [15:0] wdata,
    output var  logic [15:0] rdata
);
    logic [15:0] mem [0:127];

    // Registered read keeps the output a flip-flop
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // esp_param_mem

`default_nettype wire

// [esp_status_checker.sv]
// Port checker of the status core.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module esp_status_checker
    import esp_pkg::*;
#(parameter int unsigned ACCESS_CYCLES = 50) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        link_dout,
    input wire logic        link_doe,
    input wire logic [1:0]  warn_src,
    input wire logic        ref_mark,
    input wire logic [3:0]  sensor_addr,
    input wire logic        tolerance_warning_flag,
    input wire logic        reference_done_flag,
    input wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] busy_len;
    // Length of the running busy stretch
    always_ff @(posedge clk) begin
        if (!nrst || !busy)
            busy_len <= '0;
        else
            busy_len <= busy_len + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_ack;
        avs_read && !avs_waitrequest;
    endsequence
    a_warn_flag: assert property ($past(nrst) |-> tolerance_warning_flag == |$past(warn_src))
        else $error("warning flag differs from sources");
    a_ref_latch: assert property (ref_mark |-> ##[1:2] reference_done_flag)
        else $error("reference flag missing");
    a_bus_answer: assert property (s_req |-> ##[1:2] !avs_waitrequest)
        else $error("bus access not answered");
    a_busy_span: assert property ($past(nrst) && $fell(busy)
        |-> busy_len >= ACCESS_CYCLES - 1 && busy_len <= ACCESS_CYCLES + 1)
        else $error("busy span wrong");
    a_read_unmapped: assert property (s_rd_ack and avs_address > REG_MEM_DATA |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_view: assert property (s_rd_ack and avs_address == REG_STATUS
        |-> avs_readdata[2:0] == {busy, reference_done_flag, tolerance_warning_flag})
        else $error("status bits differ from flags");
    a_link_quiet: assert property (!link_doe |-> !link_dout)
        else $error("data driven outside frame");
    a_sensor_roll: assert property ($past(nrst) && $changed(sensor_addr)
        |-> sensor_addr == 4'($past(sensor_addr) + 4'h1))
        else $error("sensor address skipped");
endmodule // esp_status_checker
bind esp_status_core esp_status_checker #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_esp_status_checker (.clk, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .link_dout, .link_doe, .warn_src,
    .ref_mark, .sensor_addr, .tolerance_warning_flag, .reference_done_flag, .busy);
`default_nettype wire

// [esp_ctrl_model.sv]
// Link controller model: clock frames out, command in, word back.
// Assumes the core samples on rising, drives after falling edges.
`default_nettype none
module esp_ctrl_model (
    output var  logic link_clk,
    output var  logic link_din,
    input  wire logic link_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock stands high between frames
    initial begin
        link_clk = 1'b1;
        link_din = 1'b0;
    end
    // One 37-period frame at 160 ns
    task automatic frame(input logic [23:0] cmd, output logic [36:0] rx);
        #2000;  // Gap covers recovery and access time
        for (int i = 0; i < 37; i++) begin
            link_clk = 1'b0;
            #40 link_din = (i < 24) ? cmd[23 - i] : ~link_din;  // Spare bits toggle
            #40 rx[36 - i] = link_dout;
            link_clk = 1'b1;
            #80;
        end
    endtask
endmodule // esp_ctrl_model
`default_nettype wire

// [encoder_status_param_memory_test.sv]
// Bench of the status core; register bus plus link model.
// Assumes the checker is bound by its own file.
`default_nettype none
module encoder_status_param_memory_test;
    timeunit 1ns;
    timeprecision 1ps;
    import esp_pkg::*;
    localparam logic [15:0] ENC = 16'h00A5;  // Arbitrary type code
    logic        clk, avs_waitrequest, link_clk, link_din, link_dout, link_doe, busy;
    logic        tolerance_warning_flag, reference_done_flag;
    logic        nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, fault_b = 1'b0, ref_mark = 1'b0, inc_step = 1'b0;
    logic        fault_a = 1'b0;
    logic [1:0]  warn_src = 2'h0;
    logic [15:0] pos_safe = 16'h2D4B;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic [3:0]  sensor_addr, a0;
    logic [36:0] rx;
    int          err_count = 0, samples_checked = 0;
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    esp_status_core #(.ACCESS_CYCLES(50), .ENC_TYPE(ENC)) u_esp_status_core (.clk, .nrst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .link_clk, .link_din, .link_dout, .link_doe,
        .warn_src, .fault_a, .fault_b, .ref_mark, .inc_step, .inc_dir(1'b0), .pos_abs(16'h0000),
        .pos_safe, .sensor_value(16'h0000), .sensor_addr, .tolerance_warning_flag,
        .reference_done_flag, .busy);
    esp_ctrl_model u_esp_ctrl_model (.link_clk, .link_din, .link_dout);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Avalon access; answer taken at the ack edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic fr(input logic [1:0] op, input logic [4:0] f, input logic [15:0] d);
        u_esp_ctrl_model.frame({op, 1'b0, f, d}, rx);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #300_000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        chk({busy, reference_done_flag, tolerance_warning_flag, sensor_addr}, 0);
        bus(1'b0, 5'h14, 0, q);
        chk(q, 0);
        for (int i = 1; i < 3; i++) begin
            warn_src <= 2'(i);
            repeat (3) @(posedge clk);
            chk(tolerance_warning_flag, 1);
            warn_src <= 2'h0;
            bus(1'b0, REG_CAUSE, 0, q);
            chk(q, i);
            bus(1'b1, REG_CAUSE, 32'hFFFF_FFFF, q);
        end
        $display("warning test done");
        repeat (3) begin
            inc_step <= 1'b1;
            @(posedge clk);
            inc_step <= 1'b0;
            @(posedge clk);
        end
        fr(2'h1, 5'h04, 0);
        fr(2'h0, 5'h00, 0);
        chk(rx[35:5], {2'h2, 3'h0, CID_POS2, 5'h00, 16'h0003});
        $display("second position test done");
        bus(1'b1, REG_CTRL, 1, q);
        chk(reference_done_flag, 1);
        fr(2'h0, 5'h00, 0);
        chk(rx[20:5], pos_safe);
        bus(1'b1, REG_CTRL, 0, q);
        ref_mark <= 1'b1;
        @(posedge clk);
        ref_mark <= 1'b0;
        bus(1'b0, REG_STATUS, 0, q);
        chk(q[1], 1);
        $display("reference test done");
        {fault_a, fault_b} <= 2'h3;
        bus(1'b1, REG_MEM_ADDR, 14, q);
        bus(1'b1, REG_MEM_DATA, ENC, q);
        fr(2'h1, 5'h08, 0);
        fr(2'h2, 5'd14, 0);
        fr(2'h3, 5'd14, 16'hBEEF);
        chk(rx[36:5], {6'h22, CID_MEMPAR, 5'd14, ENC});
        bus(1'b0, REG_MEM_DATA, 0, q);
        chk(q, ENC);
        fr(2'h1, 5'h0E, 0);
        fr(2'h3, 5'd3, 16'h5A5A);
        chk(rx[30:21], {CID_ACK, 5'h0E});
        fr(2'h1, 5'h0F, 0);
        fr(2'h3, 5'd1, 16'h0002);
        fr(2'h3, 5'd1, 16'h0000);
        fr(2'h1, 5'h0E, 0);
        fr(2'h3, 5'd3, 16'h1111);
        bus(1'b1, REG_MEM_ADDR, 32'h0000_0043, q);
        bus(1'b0, REG_MEM_DATA, 0, q);
        chk(q, 32'h0000_5A5A);
        bus(1'b0, REG_STATUS, 0, q);
        chk(q[4:3], 2'h2);
        $display("protection test done");
        fr(2'h1, 5'h10, 0);
        a0 = sensor_addr;
        fr(2'h0, 5'h00, 0);
        chk(sensor_addr, 4'(a0 + 4'h1));
        chk(rx[30:21], {CID_SENSOR, 1'b0, a0});
        $display("sensor test done");
        wrap_up();
    end
endmodule // encoder_status_param_memory_test
`default_nettype wire
